// [verilog/dfr_decrement_core.sv]
// decode and execute unit for the decrement-file-register instruction
// assumes a same-clock data memory answering a read strobe one cycle later
//
// Summary of operation
// - recognise word 0000 01da ffff ffff as the decrement instruction
// - compute addressed byte minus one and route it to a destination
// - destination bit 0 writes working register, 1 writes back to memory
// - access bit 0 uses access bank, 1 takes bank from bank select register
// - access 0 with extended set and address at most 5f uses indexed offset
// - decrement updates carry, digit carry, negative, overflow and zero flags
// - one word, one cycle: decode, read, process, write in four quarters
// - decrement-skip-zero accepts the same file, destination and access operands
//
// Decided for this implementation: strobed register access and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module dfr_decrement_core #(
  parameter int BANK_W = 4
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic reset_i,
  // register port
  input wire logic [dfr_pkg::REG_AW-1:0] reg_addr_i,
  input wire logic [dfr_pkg::BUS_DW-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [dfr_pkg::BUS_DW-1:0] reg_rdata_o,
  // data memory port
  output logic [BANK_W+dfr_pkg::FILE_W-1:0] mem_addr_o,
  output logic mem_rd_o,
  input wire logic [dfr_pkg::BYTE_W-1:0] mem_rdata_i,
  output logic mem_wr_o,
  output logic [dfr_pkg::BYTE_W-1:0] mem_wdata_o,
  // core state
  output logic [dfr_pkg::BYTE_W-1:0] working_register_o,
  output logic [dfr_pkg::FLAG_W-1:0] flags_o,
  output logic busy_o
);
  localparam int AW = BANK_W + dfr_pkg::FILE_W;

  generate
    if (BANK_W < 1 || BANK_W > dfr_pkg::BUS_DW - dfr_pkg::FILE_W) begin : g_bad_bank
      $error("dfr_decrement_core: BANK_W out of range");
    end
  endgenerate

  dfr_pkg::dfr_phase_e phase;
  logic [dfr_pkg::INSN_W-1:0] insn;
  logic ext_en;
  logic [BANK_W-1:0] bank_select_register;
  logic [AW-1:0] index_base;
  logic illegal;
  logic exec_dest;
  logic exec_is_dec;
  logic [dfr_pkg::BYTE_W-1:0] operand;
  logic [dfr_pkg::BYTE_W-1:0] result;
  logic [dfr_pkg::FLAG_W-1:0] flags_pend;

  logic launch;
  logic is_dec;
  logic is_dsz;
  logic recognised;
  logic [AW-1:0] next_addr;
  logic indexed;
  logic [dfr_pkg::BYTE_W-1:0] alu_result;
  logic [dfr_pkg::FLAG_W-1:0] alu_flags;
  logic [dfr_pkg::BUS_DW-1:0] next_rdata;

  // a new word is only taken while idle; writes during execution are dropped
  assign launch = reg_wr_i && (reg_addr_i == dfr_pkg::REG_INSN) && (phase == dfr_pkg::PH_IDLE);
  assign is_dec = (insn[dfr_pkg::INSN_W-1:dfr_pkg::OPC_LSB] == dfr_pkg::OPC_DEC);
  assign is_dsz = (insn[dfr_pkg::INSN_W-1:dfr_pkg::OPC_LSB] == dfr_pkg::OPC_DSZ);
  assign recognised = is_dec || is_dsz;

  dfr_addr_unit #(
    .BANK_W(BANK_W)
  ) u_addr (
    .file_addr_i(insn[dfr_pkg::FILE_W-1:0]),
    .access_sel_i(insn[dfr_pkg::ACC_BIT]),
    .ext_en_i(ext_en),
    .bank_i(bank_select_register),
    .index_i(index_base),
    .addr_o(next_addr),
    .indexed_o(indexed)
  );

  dfr_dec_alu u_alu (
    .operand_i(mem_rdata_i),
    .result_o(alu_result),
    .flags_o(alu_flags)
  );

  // quarter phase sequencer
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      phase <= dfr_pkg::PH_IDLE;
    end else begin
      unique case (phase)
        dfr_pkg::PH_IDLE: begin
          if (launch) begin
            phase <= dfr_pkg::PH_Q1;
          end
        end
        dfr_pkg::PH_Q1: begin
          phase <= recognised ? dfr_pkg::PH_Q2 : dfr_pkg::PH_IDLE;
        end
        dfr_pkg::PH_Q2: begin
          phase <= dfr_pkg::PH_Q3;
        end
        dfr_pkg::PH_Q3: begin
          phase <= dfr_pkg::PH_Q4;
        end
        dfr_pkg::PH_Q4: begin
          phase <= dfr_pkg::PH_IDLE;
        end
        // three of the eight codes are unused; recover to idle if one appears
        default: begin
          phase <= dfr_pkg::PH_IDLE;
        end
      endcase
    end
  end

  // instruction word and decoded controls
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      insn <= dfr_pkg::INSN_RST;
      exec_dest <= 1'b0;
      exec_is_dec <= 1'b0;
    end else begin
      if (launch) begin
        insn <= reg_wdata_i;
      end
      if (phase == dfr_pkg::PH_Q1) begin
        exec_dest <= insn[dfr_pkg::DEST_BIT];
        exec_is_dec <= is_dec;
      end
    end
  end

  // an unknown word is reported and retired after decode
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      illegal <= 1'b0;
    end else if (phase == dfr_pkg::PH_Q1 && !recognised) begin
      illegal <= 1'b1;
    end else if (launch) begin
      illegal <= 1'b0;
    end
  end

  // memory read in the second quarter
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      mem_addr_o <= '0;
      mem_rd_o <= 1'b0;
    end else begin
      mem_rd_o <= (phase == dfr_pkg::PH_Q1) && recognised;
      if (phase == dfr_pkg::PH_Q1 && recognised) begin
        mem_addr_o <= next_addr;
      end
    end
  end

  // process data in the third quarter
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      operand <= dfr_pkg::BYTE_RST;
      result <= dfr_pkg::BYTE_RST;
      flags_pend <= dfr_pkg::FLAGS_RST;
    end else if (phase == dfr_pkg::PH_Q3) begin
      operand <= mem_rdata_i;
      result <= alu_result;
      flags_pend <= alu_flags;
    end
  end

  // write-back to the file location in the fourth quarter
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      mem_wr_o <= 1'b0;
      mem_wdata_o <= dfr_pkg::BYTE_RST;
    end else begin
      mem_wr_o <= (phase == dfr_pkg::PH_Q3) && exec_dest;
      if (phase == dfr_pkg::PH_Q3) begin
        mem_wdata_o <= alu_result;
      end
    end
  end

  // working register: the core's own write wins over a software write
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      working_register_o <= dfr_pkg::BYTE_RST;
    end else if (phase == dfr_pkg::PH_Q4 && !exec_dest) begin
      working_register_o <= result;
    end else if (reg_wr_i && reg_addr_i == dfr_pkg::REG_WORK) begin
      working_register_o <= reg_wdata_i[dfr_pkg::BYTE_W-1:0];
    end
  end

  // arithmetic flags; the skip form leaves them alone
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      flags_o <= dfr_pkg::FLAGS_RST;
    end else if (phase == dfr_pkg::PH_Q4 && exec_is_dec) begin
      flags_o <= flags_pend;
    end
  end

  // software configuration registers
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      ext_en <= 1'b0;
      bank_select_register <= '0;
      index_base <= '0;
    end else if (reg_wr_i) begin
      if (reg_addr_i == dfr_pkg::REG_CTRL) begin
        ext_en <= reg_wdata_i[dfr_pkg::CTRL_EXT_BIT];
      end
      if (reg_addr_i == dfr_pkg::REG_BANK) begin
        bank_select_register <= reg_wdata_i[BANK_W-1:0];
      end
      if (reg_addr_i == dfr_pkg::REG_INDEX) begin
        index_base <= reg_wdata_i[AW-1:0];
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      busy_o <= 1'b0;
    end else begin
      busy_o <= launch || (phase != dfr_pkg::PH_IDLE && phase != dfr_pkg::PH_Q4);
    end
  end

  // read mux; unmapped indices read as zero
  always_comb begin
    next_rdata = '0;
    unique case (reg_addr_i)
      dfr_pkg::REG_CTRL: next_rdata[dfr_pkg::CTRL_EXT_BIT] = ext_en;
      dfr_pkg::REG_BANK: next_rdata[BANK_W-1:0] = bank_select_register;
      dfr_pkg::REG_WORK: next_rdata[dfr_pkg::BYTE_W-1:0] = working_register_o;
      dfr_pkg::REG_STATUS: begin
        next_rdata[dfr_pkg::FLAG_W-1:0] = flags_o;
        next_rdata[dfr_pkg::ST_BUSY] = busy_o;
        next_rdata[dfr_pkg::ST_ILLEGAL] = illegal;
      end
      dfr_pkg::REG_INDEX: next_rdata[AW-1:0] = index_base;
      dfr_pkg::REG_INSN: next_rdata = insn;
      dfr_pkg::REG_RESULT: next_rdata[dfr_pkg::BYTE_W-1:0] = result;
      default: next_rdata = '0;
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      reg_rdata_o <= '0;
    end else if (reg_rd_i) begin
      reg_rdata_o <= next_rdata;
    end else begin
      reg_rdata_o <= '0;
    end
  end

  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (reset_i);

  a_opcode_reject: assert property (
    phase == dfr_pkg::PH_Q1 && !recognised |=> phase == dfr_pkg::PH_IDLE && illegal && !mem_rd_o)
    else $error("unknown word was not rejected");

  a_phase_order: assert property (
    phase == dfr_pkg::PH_Q1 && recognised
      |=> phase == dfr_pkg::PH_Q2 && mem_rd_o ##1 phase == dfr_pkg::PH_Q3 && !mem_rd_o
      ##1 phase == dfr_pkg::PH_Q4 ##1 phase == dfr_pkg::PH_IDLE)
    else $error("quarter phases out of order");

  a_write_value: assert property (
    mem_wr_o |-> phase == dfr_pkg::PH_Q4 && mem_wdata_o == dfr_pkg::BYTE_W'(operand - dfr_pkg::DEC_STEP))
    else $error("written byte is not operand minus one");

  a_dest_select: assert property (
    phase == dfr_pkg::PH_Q4 && !exec_dest |-> !mem_wr_o ##1 working_register_o == $past(result))
    else $error("working register destination not honoured");

  a_bank_addr: assert property (
    phase == dfr_pkg::PH_Q1 && recognised && insn[dfr_pkg::ACC_BIT]
      |=> mem_addr_o[AW-1:dfr_pkg::FILE_W] == $past(bank_select_register))
    else $error("banked address does not use bank select");

  a_indexed_addr: assert property (
    phase == dfr_pkg::PH_Q1 && recognised && !insn[dfr_pkg::ACC_BIT] && ext_en
      && insn[dfr_pkg::FILE_W-1:0] <= dfr_pkg::LIT_OFFSET_MAX
      |=> mem_addr_o == AW'($past(index_base) + AW'($past(insn[dfr_pkg::FILE_W-1:0]))))
    else $error("indexed offset address wrong");

  a_zero_flag: assert property (
    phase == dfr_pkg::PH_Q4 && exec_is_dec
      |=> flags_o[dfr_pkg::ST_Z] == ($past(result) == dfr_pkg::BYTE_RST)
      && flags_o[dfr_pkg::ST_N] == $past(result[dfr_pkg::BYTE_W-1]))
    else $error("zero or negative flag wrong");

  a_borrow_flags: assert property (
    phase == dfr_pkg::PH_Q4 && exec_is_dec
      |=> flags_o[dfr_pkg::ST_C] == ($past(operand) != dfr_pkg::BYTE_RST)
      && flags_o[dfr_pkg::ST_OV] == ($past(operand) == dfr_pkg::SIGN_MIN))
    else $error("carry or overflow flag wrong");

  a_skip_flags: assert property (
    phase == dfr_pkg::PH_Q4 && !exec_is_dec |=> $stable(flags_o))
    else $error("skip form disturbed flags");

endmodule
`default_nettype wire

// [verilog/dfr_pkg.sv]
// constants shared by the decrement-file-register executor and its helpers
// assumes a single 100 MHz core clock; nothing here holds state
package dfr_pkg;

  // core clock and register bus geometry
  localparam int CLK_PERIOD_NS = 10;
  localparam int BUS_DW = 16;
  localparam int REG_AW = 4;
  localparam int BYTE_W = 8;

  // register indices on the plain register port
  localparam logic [REG_AW-1:0] REG_CTRL = 4'h0;
  localparam logic [REG_AW-1:0] REG_BANK = 4'h1;
  localparam logic [REG_AW-1:0] REG_WORK = 4'h2;
  localparam logic [REG_AW-1:0] REG_STATUS = 4'h3;
  localparam logic [REG_AW-1:0] REG_INDEX = 4'h4;
  localparam logic [REG_AW-1:0] REG_INSN = 4'h5;
  localparam logic [REG_AW-1:0] REG_RESULT = 4'h6;

  // control register fields
  localparam int CTRL_EXT_BIT = 0;

  // status register fields
  localparam int ST_C = 0;
  localparam int ST_DC = 1;
  localparam int ST_Z = 2;
  localparam int ST_OV = 3;
  localparam int ST_N = 4;
  localparam int ST_BUSY = 5;
  localparam int ST_ILLEGAL = 6;
  localparam int FLAG_W = 5;

  // instruction word layout
  localparam int INSN_W = 16;
  localparam int OPC_LSB = 10;
  localparam int DEST_BIT = 9;
  localparam int ACC_BIT = 8;
  localparam int FILE_W = 8;
  localparam logic [5:0] OPC_DEC = 6'h01;
  localparam logic [5:0] OPC_DSZ = 6'h0b;

  // addressing and arithmetic constants
  localparam logic [FILE_W-1:0] LIT_OFFSET_MAX = 8'h5f;
  localparam logic [FILE_W-1:0] DEC_STEP = 8'h01;
  localparam logic [3:0] NIBBLE_ZERO = 4'h0;
  localparam logic [FILE_W-1:0] SIGN_MIN = 8'h80;

  // reset values
  localparam logic [FLAG_W-1:0] FLAGS_RST = 5'h00;
  localparam logic [BYTE_W-1:0] BYTE_RST = 8'h00;
  localparam logic [INSN_W-1:0] INSN_RST = 16'h0000;

  // quarter phases of one instruction cycle
  typedef enum logic [2:0] {PH_IDLE, PH_Q1, PH_Q2, PH_Q3, PH_Q4} dfr_phase_e;

endpackage

// [verilog/dfr_addr_unit.sv]
// operand address former for byte-oriented file instructions
// assumes the caller supplies stable operand fields during the decode phase
`timescale 1ns/10ps
`default_nettype none
module dfr_addr_unit #(
  parameter int BANK_W = 4
) (
  // operand fields
  input wire logic [dfr_pkg::FILE_W-1:0] file_addr_i,
  input wire logic access_sel_i,
  // mode and base registers
  input wire logic ext_en_i,
  input wire logic [BANK_W-1:0] bank_i,
  input wire logic [BANK_W+dfr_pkg::FILE_W-1:0] index_i,
  // formed address
  output logic [BANK_W+dfr_pkg::FILE_W-1:0] addr_o,
  output logic indexed_o
);
  localparam int AW = BANK_W + dfr_pkg::FILE_W;
  logic [AW-1:0] sum;

  assign sum = AW'(index_i + AW'(file_addr_i));
  // access-bank addresses up to 5f sit in bank zero unless indexed, the rest in the top bank
  assign indexed_o = !access_sel_i && ext_en_i && (file_addr_i <= dfr_pkg::LIT_OFFSET_MAX);

  always_comb begin
    if (access_sel_i) begin
      addr_o = {bank_i, file_addr_i};
    end else if (indexed_o) begin
      addr_o = sum;
    end else if (file_addr_i <= dfr_pkg::LIT_OFFSET_MAX) begin
      addr_o = {{BANK_W{1'b0}}, file_addr_i};
    end else begin
      addr_o = {{BANK_W{1'b1}}, file_addr_i};
    end
  end
endmodule
`default_nettype wire

// [verilog/dfr_dec_alu.sv]
// byte decrementer with arithmetic flag generation
// purely combinational; the caller registers both result and flags
`timescale 1ns/10ps
`default_nettype none
module dfr_dec_alu (
  // operand
  input wire logic [dfr_pkg::BYTE_W-1:0] operand_i,
  // result and flags
  output logic [dfr_pkg::BYTE_W-1:0] result_o,
  output logic [dfr_pkg::FLAG_W-1:0] flags_o
);
  assign result_o = dfr_pkg::BYTE_W'(operand_i - dfr_pkg::DEC_STEP);
  // carries are inverted borrows of the subtraction of one
  assign flags_o[dfr_pkg::ST_C] = (operand_i != dfr_pkg::BYTE_RST);
  assign flags_o[dfr_pkg::ST_DC] = (operand_i[3:0] != dfr_pkg::NIBBLE_ZERO);
  assign flags_o[dfr_pkg::ST_Z] = (result_o == dfr_pkg::BYTE_RST);
  assign flags_o[dfr_pkg::ST_OV] = (operand_i == dfr_pkg::SIGN_MIN);
  assign flags_o[dfr_pkg::ST_N] = result_o[dfr_pkg::BYTE_W-1];
endmodule
`default_nettype wire

// [bench/testbench.sv]
// self-checking bench for the decrement-file-register executor
// drives the register port and plays a same-clock data memory itself
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin failures++; \
  $display("MISMATCH %s expected %h seen %h", nm, ex, got); end end
module testbench;
  logic sys_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [3:0] reg_addr_i = 4'h0;
  logic [15:0] reg_wdata_i = 16'h0000;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [15:0] reg_rdata_o;
  logic [11:0] mem_addr_o;
  logic mem_rd_o;
  logic mem_wr_o;
  logic [7:0] mem_rdata_i = 8'h00;
  logic [7:0] mem_wdata_o;
  logic [7:0] working_register_o;
  logic [4:0] flags_o;
  logic busy_o;
  int failures = 0;
  int comparisons = 0;
  int cycles = 0;
  logic rd_seen = 1'b0;
  logic busy_d = 1'b0;
  logic [12:0] e13;
  logic [12:0] q_core[$];
  logic [15:0] e16;
  logic [11:0] e12;
  logic [7:0] e8;
  // expected results, oldest first, one queue per output
  logic [15:0] q_rd[$];
  logic [11:0] q_addr[$];
  logic [7:0] q_wr[$];
  // reference state of the core
  logic [7:0] mem_byte = 8'h00;
  logic [7:0] w = 8'h00;
  logic [7:0] res = 8'h00;
  logic [4:0] flg = 5'h00;
  logic ill = 1'b0;
  logic ext = 1'b0;
  logic [3:0] bank = 4'h0;
  logic [11:0] index = 12'h000;

  dfr_decrement_core #(.BANK_W(4)) i_dfr_decrement_core (
    .sys_clk_i(sys_clk_i),
    .reset_i(reset_i),
    .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o),
    .mem_addr_o(mem_addr_o),
    .mem_rd_o(mem_rd_o),
    .mem_rdata_i(mem_rdata_i),
    .mem_wr_o(mem_wr_o),
    .mem_wdata_o(mem_wdata_o),
    .working_register_o(working_register_o),
    .flags_o(flags_o),
    .busy_o(busy_o)
  );

  always #5 sys_clk_i = ~sys_clk_i;

  task automatic end_sim();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // about 1120 cycles are needed; a hang is cut well after that
  always @(posedge sys_clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      end_sim();
    end
  end

  // watcher and memory: an output with no note expects x, so it always mismatches
  always @(posedge sys_clk_i) begin
    if (rd_seen) begin
      e16 = (q_rd.size() > 0) ? q_rd.pop_front() : 'x;
      `CHK("reg_rdata_o", e16, reg_rdata_o)
    end
    if (mem_rd_o === 1'b1) begin
      e12 = (q_addr.size() > 0) ? q_addr.pop_front() : 'x;
      `CHK("mem_addr_o", e12, mem_addr_o)
      `CHK("busy_o", 1'b1, busy_o)
      mem_rdata_i <= mem_byte;
    end else begin
      // outside the answer cycle the data lines carry nothing useful
      mem_rdata_i <= ~mem_rdata_i;
    end
    if (mem_wr_o === 1'b1) begin
      e8 = (q_wr.size() > 0) ? q_wr.pop_front() : 'x;
      `CHK("mem_wdata_o", e8, mem_wdata_o)
    end
    // completion: busy has just dropped, so flags and working register have settled
    if (busy_d === 1'b1 && busy_o === 1'b0) begin
      e13 = (q_core.size() > 0) ? q_core.pop_front() : 'x;
      `CHK("flags_o working_register_o", e13, {flags_o, working_register_o})
    end
    busy_d <= busy_o;
    rd_seen <= reg_rd_i;
  end

  // each bus cycle leaves one idle cycle after it so a strobe is never set twice at one edge
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b0;
    @(posedge sys_clk_i);
  endtask

  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    q_rd.push_back(e);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge sys_clk_i);
    reg_rd_i <= 1'b0;
    @(posedge sys_clk_i);
  endtask

  task automatic launch(input logic [15:0] word);
    logic [5:0] opc;
    logic [7:0] f;
    logic [7:0] r;
    opc = word[15:10];
    f = word[7:0];
    r = mem_byte - 8'h01;
    ill = !(opc == dfr_pkg::OPC_DEC || opc == dfr_pkg::OPC_DSZ);
    if (!ill) begin
      if (word[8]) q_addr.push_back({bank, f});
      else if (f <= 8'h5f) q_addr.push_back(ext ? index + {4'h0, f} : {4'h0, f});
      else q_addr.push_back({4'hf, f});
      if (word[9]) q_wr.push_back(r);
      else w = r;
      if (opc == dfr_pkg::OPC_DEC) begin
        flg = {r[7], mem_byte == 8'h80, r == 8'h00, mem_byte[3:0] != 4'h0, mem_byte != 8'h00};
      end
      res = r;
    end
    q_core.push_back({flg, w});
    wr(dfr_pkg::REG_INSN, word);
    if (!ill) begin
      // a second launch while running must leave no trace at all
      wr(dfr_pkg::REG_INSN, 16'h0401);
    end
    repeat (2) @(posedge sys_clk_i);
    rd(dfr_pkg::REG_WORK, {8'h00, w});
    rd(dfr_pkg::REG_STATUS, {9'h000, ill, 1'b0, flg});
    rd(dfr_pkg::REG_INSN, word);
    rd(dfr_pkg::REG_RESULT, {8'h00, res});
  endtask

  initial begin
    logic [15:0] word;
    logic [15:0] msk[5];
    logic [7:0] pick[4];
    msk = '{16'h0001, 16'h000f, 16'h00ff, 16'h0000, 16'h0fff};
    pick = '{8'h00, 8'h80, 8'h01, 8'h10};
    void'($urandom(32'hc98c58e6));
    repeat (16) @(posedge sys_clk_i);
    reset_i <= 1'b0;
    for (int a = 0; a < 16; a++) begin
      rd(a[3:0], 16'h0000);
    end
    foreach (msk[i]) begin
      wr(i[3:0], 16'hffff);
      rd(i[3:0], msk[i]);
    end
    wr(4'h9, 16'hffff);
    rd(4'h9, 16'h0000);
    for (int n = 0; n < 48; n++) begin
      ext = 1'($urandom());
      bank = 4'($urandom());
      index = 12'($urandom());
      w = 8'($urandom());
      mem_byte = (n < 4) ? pick[n] : 8'($urandom());
      word = {($urandom_range(0, 1) == 1) ? dfr_pkg::OPC_DSZ : dfr_pkg::OPC_DEC, 10'($urandom())};
      if (n < 4) word[15:10] = dfr_pkg::OPC_DEC;
      if (n % 7 == 6) word[15:10] = 6'h3f;
      if (n % 8 == 2) word[7:0] = 8'h5f;
      if (n % 8 == 3) word[7:0] = 8'h60;
      wr(dfr_pkg::REG_CTRL, {15'h0000, ext});
      wr(dfr_pkg::REG_BANK, {12'h000, bank});
      wr(dfr_pkg::REG_INDEX, {4'h0, index});
      wr(dfr_pkg::REG_WORK, {8'h00, w});
      launch(word);
    end
    repeat (4) @(posedge sys_clk_i);
    end_sim();
  end
endmodule
`default_nettype wire
